//--- include/acr_pkg.sv
// constants, carriers and state type for the converter control block
// What this block does
// - right justified: high result byte bits 7..2 loaded as zeros
// - left justified: low result byte bits 5..0 loaded as zeros
// - clock field picks system clock /2,/8,/32,/4,/16,/64 or RC oscillator
// - negative reference: external pin when set, ground when clear
// - positive reference: supply, external pin or fixed reference; 01 reserved
// - left justified: result bits 9..2 go to high result byte
// - left justified: result bits 1..0 go to low byte bits 7..6
// - right justified: result bits 9..8 go to high byte bits 1..0
// - right justified: result bits 7..0 go to low result byte
// - second control register resets to zero; bit 3 reads zero
// - result bytes read/write; zero after reset, kept otherwise
// - enable powers converter; busy bit starts conversion, not with enable
// - on completion: clear busy, set done flag, load result bytes
// - early clear of busy loads partial result, unconverted bits copy last, unless a bit is decided that cycle
// - channel field: inputs 0..16, temperature, converter output, reference
package acr_pkg;
    localparam int RES_W = 10;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_RESH = 8'h08;
    localparam logic [7:0] OFF_RESL = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    // control 0 fields
    localparam int C0_EN = 0;
    localparam int C0_BUSY = 1;
    localparam int C0_CHS_LSB = 2;
    // control 1 fields
    localparam int C1_PREF_LSB = 0;
    localparam int C1_NREF = 2;
    localparam int C1_CS_LSB = 4;
    localparam int C1_FMT = 7;
    localparam logic [7:0] C1_WMASK = 8'hf7;
    localparam logic [7:0] C1_RESET = 8'h00;
    localparam logic [1:0] PREF_RSVD = 2'h1;
    // conversion clock codes
    localparam logic [2:0] CS_DIV2 = 3'h0;
    localparam logic [2:0] CS_DIV8 = 3'h1;
    localparam logic [2:0] CS_DIV32 = 3'h2;
    localparam logic [2:0] CS_RC_A = 3'h3;
    localparam logic [2:0] CS_DIV4 = 3'h4;
    localparam logic [2:0] CS_DIV16 = 3'h5;
    localparam logic [2:0] CS_DIV64 = 3'h6;
    localparam logic [2:0] CS_RC_B = 3'h7;
    // channel codes
    localparam logic [4:0] CH_LAST_INPUT = 5'h10;
    localparam logic [4:0] CH_TEMP = 5'h1d;
    localparam logic [4:0] CH_DAC = 5'h1e;
    localparam logic [4:0] CH_FIXED_REF = 5'h1f;
    localparam int IRQ_DONE = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONVERT} acr_conv_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } acr_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } acr_axi_rsp_t;

    typedef struct packed {
        logic convEnable;
        logic sampleClosed;
        logic [RES_W-1:0] trialCode;
        logic [4:0] channelSelect;
        logic channelConnected;
        logic negRefExternal;
        logic [1:0] posRefSelect;
        logic clockFromRc;
    } acr_analog_t;

    typedef struct packed {
        acr_axi_rsp_t axi;
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [7:0] wData;
        logic wLane0;
        logic [4:0] chanSel;
        logic convEn;
        logic [7:0] ctrl1;
        logic [7:0] resHigh;
        logic [7:0] resLow;
        logic [0:0] irqStat;
        logic [0:0] irqMask;
        acr_conv_t conv;
        logic [3:0] bitIdx;
        logic [RES_W-1:0] sar;
        logic [5:0] divCnt;
        logic [2:0] compSync;
        logic compLevel;
        logic [2:0] rcSync;
        logic rcLevel;
        logic rcPrev;
        acr_analog_t ana;
        logic irq;
    } acr_state_t;
endpackage

//--- design/acr_converter_ctrl.sv
// converter control, result formatting and register slave
`timescale 1ns/1ps
module acr_converter_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire acr_pkg::acr_axi_req_t axiReq,
    output acr_pkg::acr_axi_rsp_t axiRsp,
    input wire logic compHigh,
    input wire logic rcOscPin,
    output acr_pkg::acr_analog_t analog,
    output logic irq
);
    import acr_pkg::*;

    acr_state_t s;
    acr_state_t next_s;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] divTarget(input logic [2:0] cs);
        case (cs)
            CS_DIV2: divTarget = 6'd1;
            CS_DIV4: divTarget = 6'd3;
            CS_DIV8: divTarget = 6'd7;
            CS_DIV16: divTarget = 6'd15;
            CS_DIV32: divTarget = 6'd31;
            CS_DIV64: divTarget = 6'd63;
            default: divTarget = 6'd0;
        endcase
    endfunction

    // bits at and below idx copy the last decided bit (idx+1)
    function automatic logic [RES_W-1:0] fillPartial(
        input logic [RES_W-1:0] sar,
        input logic [3:0] idx
    );
        logic [RES_W-1:0] r;
        logic last;
        r = sar;
        last = 1'b0;
        if (idx < 4'd9) begin
            last = sar[idx + 4'd1];
        end
        for (int i = 0; i < RES_W; i++) begin
            if (4'(i) <= idx) begin
                r[i] = last;
            end
        end
        fillPartial = r;
    endfunction

    function automatic logic [15:0] formatResult(
        input logic [RES_W-1:0] res,
        input logic rightJust
    );
        if (rightJust) begin
            formatResult = {6'h00, res[9:8], res[7:0]};
        end else begin
            formatResult = {res[9:2], res[1:0], 6'h00};
        end
    endfunction

    function automatic logic [7:0] readCtrl0(input acr_state_t st);
        logic [7:0] v;
        v = 8'h00;
        v[C0_CHS_LSB +: 5] = st.chanSel;
        v[C0_BUSY] = (st.conv != ST_IDLE);
        v[C0_EN] = st.convEn;
        readCtrl0 = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic wrHit;
        logic [7:0] wv;
        logic start;
        logic abort;
        logic tick;
        logic rcSel;
        logic load;
        logic [RES_W-1:0] loadVal;
        logic [15:0] fmt;
        logic [2:0] cs;
        wrHit = 1'b0;
        cs = '0;
        rcSel = 1'b0;
        wv = s.wData;
        start = 1'b0;
        abort = 1'b0;
        tick = 1'b0;
        load = 1'b0;
        loadVal = '0;
        fmt = '0;
        next_s = s;

        // comparator answers the registered trial code on this clock;
        // a three-stage sync would decide bits stale at /2 and /4
        next_s.compLevel = compHigh;
        // rc pin: three stages, change counts when 2nd and 3rd agree
        next_s.rcSync = {s.rcSync[1:0], rcOscPin};
        if (s.rcSync[1] == s.rcSync[2]) begin
            next_s.rcLevel = s.rcSync[2];
        end
        next_s.rcPrev = s.rcLevel;

        // write address and data channels, taken in either order
        if (axiReq.awvalid && s.axi.awready) begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s.axi.wready) begin
            next_s.wHeld = 1'b1;
            next_s.wData = axiReq.wdata[7:0];
            next_s.wLane0 = axiReq.wstrb[0];
        end
        if (s.axi.bvalid && axiReq.bready) begin
            next_s.axi.bvalid = 1'b0;
        end

        if (s.awHeld && s.wHeld && !s.axi.bvalid) begin
            next_s.awHeld = 1'b0;
            next_s.wHeld = 1'b0;
            next_s.axi.bvalid = 1'b1;
            next_s.axi.bresp = RESP_OKAY;
            wrHit = s.wLane0;
            case (s.awAddr)
                OFF_CTRL0: begin
                    if (wrHit) begin
                        next_s.chanSel = wv[C0_CHS_LSB +: 5];
                        next_s.convEn = wv[C0_EN];
                        // start only if already enabled before write
                        start = wv[C0_BUSY] && wv[C0_EN] && s.convEn &&
                                (s.conv == ST_IDLE);
                        // busy cleared by software ends it early, unless a bit is decided that cycle
                        abort = !wv[C0_BUSY] && (s.conv != ST_IDLE);
                    end
                end
                OFF_CTRL1: begin
                    if (wrHit) begin
                        next_s.ctrl1 = wv & C1_WMASK;
                        if (wv[C1_PREF_LSB +: 2] == PREF_RSVD) begin
                            next_s.ctrl1[C1_PREF_LSB +: 2] =
                                s.ctrl1[C1_PREF_LSB +: 2];
                        end
                    end
                end
                OFF_RESH: begin
                    // software may write the result bytes
                    if (wrHit) begin
                        next_s.resHigh = wv;
                    end
                end
                OFF_RESL: begin
                    if (wrHit) begin
                        next_s.resLow = wv;
                    end
                end
                OFF_IRQ_STAT: begin
                    if (wrHit) begin
                        next_s.irqStat = s.irqStat & ~wv[0:0];
                    end
                end
                OFF_IRQ_MASK: begin
                    if (wrHit) begin
                        next_s.irqMask = wv[0:0];
                    end
                end
                default: next_s.axi.bresp = RESP_SLVERR;
            endcase
        end
        next_s.axi.awready = !next_s.awHeld && !next_s.axi.bvalid;
        next_s.axi.wready = !next_s.wHeld && !next_s.axi.bvalid;

        // read channel
        if (s.axi.rvalid && axiReq.rready) begin
            next_s.axi.rvalid = 1'b0;
            next_s.axi.arready = 1'b1;
        end
        if (axiReq.arvalid && s.axi.arready) begin
            next_s.axi.arready = 1'b0;
            next_s.axi.rvalid = 1'b1;
            next_s.axi.rresp = RESP_OKAY;
            next_s.axi.rdata = 32'h0000_0000;
            case (axiReq.araddr)
                OFF_CTRL0: next_s.axi.rdata[7:0] = readCtrl0(s);
                // bit 3 never stored, reads zero
                OFF_CTRL1: next_s.axi.rdata[7:0] = s.ctrl1;
                OFF_RESH: next_s.axi.rdata[7:0] = s.resHigh;
                OFF_RESL: next_s.axi.rdata[7:0] = s.resLow;
                OFF_IRQ_STAT: next_s.axi.rdata[0:0] = s.irqStat;
                OFF_IRQ_MASK: next_s.axi.rdata[0:0] = s.irqMask;
                default: next_s.axi.rresp = RESP_SLVERR;
            endcase
        end

        cs = s.ctrl1[C1_CS_LSB +: 3];
        rcSel = (cs == CS_RC_A) || (cs == CS_RC_B);
        // divided clock as one-cycle enable, restarted on start
        if (rcSel) begin
            tick = s.rcLevel && !s.rcPrev;
        end else begin
            tick = (s.divCnt == divTarget(cs));
        end
        if (start || tick || rcSel) begin
            next_s.divCnt = 6'd0;
        end else begin
            next_s.divCnt = s.divCnt + 6'd1;
        end
        if (start) begin
            tick = 1'b0;
        end

        case (s.conv)
            ST_IDLE: begin
                if (start) begin
                    next_s.conv = ST_SETTLE;
                    next_s.sar = '0;
                    next_s.bitIdx = 4'd9;
                end
            end
            ST_SETTLE: begin
                if (abort) begin
                    load = 1'b1;
                    next_s.conv = ST_IDLE;
                end else if (tick) begin
                    next_s.conv = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                // completion takes priority over a same-cycle abort
                if (tick) begin
                    next_s.sar[s.bitIdx] = s.compLevel;
                    if (s.bitIdx == 4'd0) begin
                        load = 1'b1;
                        loadVal = next_s.sar;
                        next_s.irqStat[IRQ_DONE] = 1'b1;
                        next_s.conv = ST_IDLE;
                    end else begin
                        next_s.bitIdx = s.bitIdx - 4'd1;
                    end
                end else if (abort) begin
                    // partial result, missing bits copy last one
                    load = 1'b1;
                    loadVal = fillPartial(s.sar, s.bitIdx);
                    next_s.conv = ST_IDLE;
                end
            end
            default: next_s.conv = ST_IDLE;
        endcase

        // switching the converter off drops any conversion unloaded
        if (!next_s.convEn) begin
            next_s.conv = ST_IDLE;
            load = 1'b0;
        end

        if (load) begin
            // justification taken as it stands at load
            fmt = formatResult(loadVal, s.ctrl1[C1_FMT]);
            next_s.resHigh = fmt[15:8];
            next_s.resLow = fmt[7:0];
        end

        // analog side controls
        next_s.ana.convEnable = next_s.convEn;
        next_s.ana.sampleClosed = next_s.convEn &&
                                  (next_s.conv != ST_CONVERT);
        next_s.ana.trialCode = '0;
        if (next_s.conv == ST_CONVERT) begin
            next_s.ana.trialCode = next_s.sar |
                (RES_W'(1) << next_s.bitIdx);
        end
        // channel decode, reserved codes connect nothing
        next_s.ana.channelSelect = next_s.chanSel;
        next_s.ana.channelConnected =
            (next_s.chanSel <= CH_LAST_INPUT) ||
            (next_s.chanSel == CH_TEMP) ||
            (next_s.chanSel == CH_DAC) ||
            (next_s.chanSel == CH_FIXED_REF);
        next_s.ana.negRefExternal = next_s.ctrl1[C1_NREF];
        next_s.ana.posRefSelect = next_s.ctrl1[C1_PREF_LSB +: 2];
        next_s.ana.clockFromRc =
            (next_s.ctrl1[C1_CS_LSB +: 3] == CS_RC_A) ||
            (next_s.ctrl1[C1_CS_LSB +: 3] == CS_RC_B);

        next_s.irq = |(next_s.irqStat & next_s.irqMask);
    end

    ////////////////////////////////////////////////////////////////////////
    // one reset stands for power-on: state to zero, ready flags and channelConnected to one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.ctrl1 <= C1_RESET;
            s.axi.awready <= 1'b1;
            s.axi.wready <= 1'b1;
            s.axi.arready <= 1'b1;
            s.conv <= ST_IDLE;
            s.ana.sampleClosed <= 1'b0;
            s.ana.channelConnected <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign axiRsp = s.axi;
    assign analog = s.ana;
    assign irq = s.irq;
endmodule

//--- testbench/acr_converter_ctrl_sva.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module acr_converter_ctrl_sva
    import acr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire acr_pkg::acr_axi_req_t axiReq,
    input wire acr_pkg::acr_axi_rsp_t axiRsp,
    input wire logic compHigh,
    input wire logic rcOscPin,
    input wire acr_pkg::acr_analog_t analog,
    input wire logic irq
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
logic [7:0] rdAddr;
logic c1Rd;
// address of the read in flight, to judge its data
always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        rdAddr <= 8'h00;
    end else if (axiReq.arvalid && axiRsp.arready) begin
        rdAddr <= axiReq.araddr;
    end
end
assign c1Rd = axiRsp.rvalid && rdAddr == OFF_CTRL1;
////////////////////////////////////////
property p_bit3; c1Rd |-> axiRsp.rdata[3] == 1'b0; endproperty
a_bit3: assert property (p_bit3)
    else $error("control 1 bit 3 read as one");
property p_rcsel;
    c1Rd |-> analog.clockFromRc == (axiRsp.rdata[5:4] == 2'h3);
endproperty
a_rcsel: assert property (p_rcsel)
    else $error("rc source flag disagrees with clock field");
property p_nref; c1Rd |-> analog.negRefExternal == axiRsp.rdata[2];
endproperty
a_nref: assert property (p_nref)
    else $error("negative reference disagrees with register");
property p_pref; analog.posRefSelect != PREF_RSVD; endproperty
a_pref: assert property (p_pref)
    else $error("reserved positive reference applied");
property p_sample; analog.sampleClosed |-> analog.convEnable; endproperty
a_sample: assert property (p_sample)
    else $error("sampling while converter off");
property p_trial; analog.trialCode != 10'h000 |-> !analog.sampleClosed;
endproperty
a_trial: assert property (p_trial)
    else $error("sample switch closed during conversion");
property p_chan;
    analog.channelConnected == !(analog.channelSelect >= 5'h11 &&
        analog.channelSelect <= 5'h1c);
endproperty
a_chan: assert property (p_chan)
    else $error("channel connection wrong for code");
property p_unmap;
    axiRsp.rvalid && rdAddr > OFF_IRQ_MASK |->
        axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == 32'h0;
endproperty
a_unmap: assert property (p_unmap)
    else $error("unmapped read not refused");
property p_bhold;
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp);
endproperty
a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
endmodule
bind acr_converter_ctrl acr_converter_ctrl_sva acr_converter_ctrl_sva_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .compHigh(compHigh), .rcOscPin(rcOscPin), .analog(analog), .irq(irq));

//--- testbench/acr_comp_model.sv
// comparator and rc oscillator standing in for the analog side
`timescale 1ns/1ps
module acr_comp_model
    import acr_pkg::*;
#(parameter int RC_HALF_NS = 350)
(
    input wire acr_pkg::acr_analog_t analog,
    input wire logic [9:0] level,
    output logic compHigh,
    output logic rcOscPin
);
assign compHigh = analog.convEnable && (analog.trialCode <= level);
// oscillator stands still while the converter is off
initial begin
    rcOscPin = 1'b0;
    forever begin
        #(RC_HALF_NS);
        rcOscPin = analog.convEnable ? !rcOscPin : 1'b0;
    end
end
endmodule

//--- testbench/adc_config_result_format_test.sv
// register-level bench for the converter control block
`timescale 1ns/1ps
module adc_config_result_format_test;
import acr_pkg::*;
logic sys_clk;
logic rst_n;
acr_axi_req_t req;
acr_axi_rsp_t rsp;
acr_analog_t ana;
logic compHigh;
logic rcOscPin;
logic irq;
logic [9:0] level;
logic [31:0] rd;
logic [1:0] resp;
logic [15:0] e;
int numErrors = 0;
int cmpCount = 0;
int cycles = 0;
int cyc;
time t0;
localparam logic [2:0] CODES [6] = '{CS_DIV2, CS_DIV4, CS_DIV8, CS_DIV16,
    CS_DIV32, CS_DIV64};
acr_converter_ctrl acr_converter_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .axiReq(req), .axiRsp(rsp), .compHigh(compHigh), .rcOscPin(rcOscPin),
    .analog(ana), .irq(irq));
acr_comp_model acr_comp_model_i (.analog(ana), .level(level),
    .compHigh(compHigh), .rcOscPin(rcOscPin));
initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
end
always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
        numErrors++;
        endSim();
    end
end
////////////////////////////////////////
task automatic endSim;
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
        numErrors++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.bready <= 1'b1;
    forever begin
        @(posedge sys_clk);
        if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
        if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        if (rsp.bvalid) begin
            resp = rsp.bresp;
            req.bready <= 1'b0;
            break;
        end
    end
endtask
task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    forever begin
        @(posedge sys_clk);
        if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        if (rsp.rvalid) begin
            rd = rsp.rdata;
            resp = rsp.rresp;
            req.rready <= 1'b0;
            break;
        end
    end
endtask
// right justified fills the top, left fills the bottom with zeros
function automatic logic [15:0] fmtRes(input logic [9:0] v, input logic r);
    return r ? {6'h00, v} : {v, 6'h00};
endfunction
task automatic conv(input logic [2:0] cs, input logic fmt);
    wr(OFF_CTRL1, {fmt, cs, 4'h0});
    wr(OFF_CTRL0, 8'h01);
    repeat (20) @(posedge sys_clk);
    wr(OFF_CTRL0, 8'h03);
    t0 = $time;
    rd = 32'h2;
    while (rd[1] !== 1'b0) rdr(OFF_CTRL0);
    cyc = int'(($time - t0) / 50);
endtask
task automatic chkRes(input logic fmt);
    e = fmtRes(level, fmt);
    rdr(OFF_RESH);
    chk("result high", rd, {24'h0, e[15:8]});
    rdr(OFF_RESL);
    chk("result low", rd, {24'h0, e[7:0]});
endtask
////////////////////////////////////////
initial begin
    rst_n = 1'b0;
    req = '0;
    req.wstrb = 4'h1;
    level = 10'h2a5;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdr(OFF_CTRL1);
    chk("ctrl1 reset", rd, 32'h0);
    wr(OFF_CTRL1, 8'hff);
    rdr(OFF_CTRL1);
    chk("ctrl1 ones", rd, 32'hf7);
    chk("nref", ana.negRefExternal, 32'h1);
    chk("pref", ana.posRefSelect, 32'h3);
    wr(OFF_CTRL1, 8'hf5);
    rdr(OFF_CTRL1);
    chk("pref reserved", rd, 32'hf7);
    for (int i = 0; i < 8; i++) begin
        wr(OFF_CTRL1, {1'b0, i[2:0], 4'h0});
        rdr(OFF_CTRL1);
        chk("rc source", ana.clockFromRc, i[1:0] == 2'h3);
    end
    for (int i = 0; i < 6; i++) begin
        level <= 10'h155 << i;
        conv(CODES[i], i[0]);
        chk("divide", cyc >= 11*(2<<i)-2 && cyc <= 11*(2<<i)+12, 1);
        chkRes(i[0]);
    end
    level <= 10'h2a5;
    conv(CS_RC_B, 1'b1);
    chkRes(1'b1);
    rdr(OFF_IRQ_STAT);
    chk("done flag", rd, 32'h1);
    chk("irq masked", irq, 32'h0);
    wr(OFF_IRQ_MASK, 8'h01);
    rdr(OFF_IRQ_MASK);
    chk("irq on", irq, 32'h1);
    wr(OFF_IRQ_STAT, 8'h01);
    rdr(OFF_IRQ_STAT);
    chk("flag cleared", rd, 32'h0);
    chk("irq off", irq, 32'h0);
    wr(OFF_CTRL1, 8'h00);
    chkRes(1'b1);
    wr(OFF_RESH, 8'h5a);
    rdr(OFF_RESH);
    chk("result rw", rd, 32'h5a);
    // early stop mid conversion: all decided bits are ones
    level <= 10'h3ff;
    wr(OFF_CTRL1, {1'b1, CS_DIV64, 4'h0});
    wr(OFF_CTRL0, 8'h03);
    repeat (300) @(posedge sys_clk);
    wr(OFF_CTRL0, 8'h01);
    chkRes(1'b1);
    rdr(OFF_IRQ_STAT);
    chk("no flag on abort", rd, 32'h0);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CTRL0, 8'h03);
    rdr(OFF_CTRL0);
    chk("start with enable", rd, 32'h1);
    for (int c = 16; c < 31; c += 7) begin
        wr(OFF_CTRL0, {1'b0, c[4:0], 2'b00});
        rdr(OFF_CTRL0);
        chk("channel", ana.channelConnected, c < 17 || c > 28);
    end
    rdr(8'h20);
    chk("unmapped read", resp, RESP_SLVERR);
    wr(8'h20, 8'hff);
    chk("unmapped write", resp, RESP_SLVERR);
    endSim();
end
endmodule
